// file: fuser_seq_defines.svh
// Constants for the fuser temperature sequencer.
// Included by the package and the testbench.
`ifndef FUSER_SEQ_DEFINES_SVH
`define FUSER_SEQ_DEFINES_SVH
`define TW 10
`define SW 2
`define MW 2
`define T_PW_HEAT 10'h0AA
`define T_PW_PRESS 10'h096
`define T_PP_HEAT 10'h0A0
`define T_PP_PRESS 10'h08C
`define T_ZERO 10'h000
`define SPD_STOP 2'h0
`define SPD_STD 2'h1
`define CNT_W 16
`define CNT_ONE 16'h0001
`define CNT_ZERO 16'h0000
`define PG_W 8
`define PG_ONE 8'h01
`define PG_ZERO 8'h00
`endif

// file: fuser_seq_pkg.sv
// Types for the fuser temperature sequencer.
// Assumes fuser_seq_defines.svh is on the include path.
`include "fuser_seq_defines.svh"
package fuser_seq_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_POSTWARM = 6'h02,
        ST_WAIT = 6'h04,
        ST_PROACT = 6'h08,
        ST_PRINT = 6'h10,
        ST_POSTPRINT = 6'h20,
        ST_HEATOFF = 6'h00
    } seqState_e;
    typedef logic [`TW-1:0] temp_t;
    typedef logic [`CNT_W-1:0] count_t;
endpackage : fuser_seq_pkg

// file: elapse_timer.sv
// Restartable cycle counter for state delays.
// Assumes a same-clock restart pulse and a frozen count while ce is low.
`timescale 1ns/10ps
module elapse_timer (
    input wire logic ref_clk, // Clock
    input wire logic rstn, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic restart, // Clear count to zero
    output logic [15:0] elapsed // Cycles since restart, saturating
);
    import fuser_seq_pkg::*;
    typedef struct packed {
        logic [`CNT_W-1:0] cnt;
    } timer_s;
    timer_s r;
    timer_s next_r;
    always_comb begin
        next_r = r;
        if (restart) begin
            next_r.cnt = `CNT_ZERO;
        end else if (r.cnt != {`CNT_W{1'b1}}) begin
            next_r.cnt = r.cnt + `CNT_ONE;
        end
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end
    assign elapsed = r.cnt;
endmodule : elapse_timer

// file: sync2.sv
// Two-flop synchroniser bank for sensor and controller pins.
// Assumes inputs are asynchronous levels.
`timescale 1ns/10ps
module sync2 #(
    parameter int W = 8
) (
    input wire logic ref_clk, // Clock
    input wire logic rstn, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic [W-1:0] din, // Async inputs
    output logic [W-1:0] dout // Synchronised levels
);
    import fuser_seq_pkg::*;
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_s;
    sync_s r;
    sync_s next_r;
    always_comb begin
        next_r = r;
        next_r.s1 = din;
        next_r.s2 = r.s1;
    end
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '0;
        end else if (ce) begin
            r <= next_r;
        end
    end
    assign dout = r.s2;
endmodule : sync2

// file: fuser_temperature_sequencer.sv
// Fuser mode sequencer: heater targets, roller speed, sheet interval.
// Assumes warm-up logic reports completion; sensor pins are asynchronous.
// How it works
// - After warm-up enter post-warm-up rotating; pending print request skips it.
// - Post-warm-up ends on timer, both roller temperatures reached, or power save.
// - Post-warm-up and wait target lamp one 170 plus correction, lamp two 150.
// - Post-warm-up goes to wait on timer or temperatures, whichever first.
// - Wait entered after post-warm-up, post-print or proactive rotation ends.
// - Wait moves to print on a print request.
// - Wait moves to heater-off on malfunction, misfeed or power save.
// - Print request pending at warm-up end starts proactive rotation; ends on timeout, start, fault, sleep.
// - Proactive goes to print on start accepted, heater-off on faults.
// - Print rotates rollers, heater targets chosen by media type.
// - First sheet leading edge at registration sets media speed.
// - Trailing edge at nip with next sheet loads next media settings.
// - Last sheet past exit with no request pending enters post-print.
// - Raised temperature after warm-up until page count or idle time.
// - Post-print targets lamp one 160 plus correction, lamp two 140, rotating.
// - Post-print stops rollers after first delay, wait after second delay.
// - Post-print abandoned on print request, door open, or error.
// - Heater-off forces heaters off, stops rollers and reverse roller.
// - Heater-off held until door, error and power save all clear.
// - Sheet interval activates on ambient extremes, small media or cold roller.
// - Active sheet interval widens gap from media length and speed.
// - Sheet interval cancels on wait, heater-off, or media needing none.
`timescale 1ns/10ps
module fuser_temperature_sequencer #(
    parameter logic [15:0] POSTWARM_CYC = 16'h1000, // Post-warm-up timeout
    parameter logic [15:0] PROACT_CYC = 16'h1000, // Proactive timeout
    parameter logic [15:0] PP_STOP_CYC = 16'h0800, // Post-print roller stop
    parameter logic [15:0] PP_WAIT_CYC = 16'h1000, // Post-print to wait
    parameter logic [15:0] BOOST_IDLE_CYC = 16'h2000, // Boost idle time
    parameter logic [7:0] BOOST_PAGES = 8'h10, // Boost page count
    parameter logic [9:0] BOOST_ADD = 10'h005, // Boost temperature rise
    parameter logic [9:0] COLD_THRESH = 10'h096, // Cold roller threshold
    parameter logic [15:0] GAP_UNIT = 16'h0010 // Gap per length per speed unit
) (
    input wire logic ref_clk, // Clock, 100 MHz
    input wire logic rstn, // Async reset, active low
    input wire logic ce, // Clock enable
    input wire logic warmDone, // Warm-up finished pulse
    input wire logic printReq, // Print request pin
    input wire logic printStart, // Print start accepted pin
    input wire logic malfunction, // Error or malfunction pin
    input wire logic misfeed, // Media misfeed pin
    input wire logic powerSave, // Power save pin
    input wire logic doorOpen, // Door open pin
    input wire logic leadAtRegist, // Leading edge at registration pin
    input wire logic trailAtNip, // Trailing edge past nip pin
    input wire logic trailAtExit, // Trailing edge past exit pin
    input wire logic moreSheets, // Another sheet follows pin
    input wire logic ambLowLow, // Low temp low humidity pin
    input wire logic ambHighHigh, // High temp high humidity pin
    input wire logic smallMedia, // Small width detected pin
    input wire logic mediaNoGap, // Fed media needs no widening pin
    input wire logic [9:0] heatRollTemp, // Heating roller temp, from ADC logic
    input wire logic [9:0] pressRollTemp, // Pressure roller temp, from ADC logic
    input wire logic [9:0] correction, // Lamp one correction value
    input wire logic [9:0] mediaHeatTemp, // Media lamp one target
    input wire logic [9:0] mediaPressTemp, // Media lamp two target
    input wire logic [1:0] mediaSpeed, // Media fusing speed code
    input wire logic [7:0] mediaLength, // Media length units
    output logic [9:0] lamp1Target, // Lamp one target temperature
    output logic [9:0] lamp2Target, // Lamp two target temperature
    output logic [1:0] rollerSpeed, // Roller and belt speed, 0 stop
    output logic heaterForceOff, // Force heaters off
    output logic reverseStop, // Stop reverse roller
    output logic intervalActive, // Sheet interval control active
    output logic [15:0] sheetGap, // Extra gap cycles between sheets
    output logic [5:0] seqState // Current state code
);
    import fuser_seq_pkg::*;
    localparam int NS = 14;
    typedef struct packed {
        seqState_e st;
        logic [`TW-1:0] l1;
        logic [`TW-1:0] l2;
        logic [`SW-1:0] spd;
        logic forceOff;
        logic revStop;
        logic ivl;
        logic [`CNT_W-1:0] gap;
        logic boost;
        logic [`PG_W-1:0] pages;
        logic firstSheet;
    } seq_s;
    seq_s r;
    seq_s next_r;
    logic [NS-1:0] pinIn;
    logic [NS-1:0] pin;
    logic restart;
    logic [15:0] elapsed, boostTime;
    logic faultAny;
    logic pwTempOk;

    // Gap grows with length, shrinks at higher speed code
    function automatic logic [15:0] calcGap(input logic [7:0] len, input logic [1:0] spd);
        logic [15:0] g;
        g = 16'(len) * GAP_UNIT;
        calcGap = g >> spd;
    endfunction : calcGap

    function automatic logic [9:0] boosted(input logic [9:0] t, input logic b);
        boosted = b ? 10'(t + BOOST_ADD) : t;
    endfunction : boosted

    assign pinIn = {printReq, printStart, malfunction, misfeed, powerSave, doorOpen,
                    leadAtRegist, trailAtNip, trailAtExit, moreSheets, ambLowLow,
                    ambHighHigh, smallMedia, mediaNoGap};
    sync2 #(.W(NS)) uSync (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ce(ce),
        .din(pinIn),
        .dout(pin)
    );
    wire sReq = pin[13];
    wire sStart = pin[12];
    wire sMal = pin[11];
    wire sMis = pin[10];
    wire sPs = pin[9];
    wire sDoor = pin[8];
    wire sLead = pin[7];
    wire sNip = pin[6];
    wire sExit = pin[5];
    wire sMore = pin[4];
    wire sLL = pin[3];
    wire sHH = pin[2];
    wire sSmall = pin[1];
    wire sNoGap = pin[0];

    elapse_timer uStateTmr (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ce(ce),
        .restart(restart),
        .elapsed(elapsed)
    );
    // Separate timer so standby boost expiry counts only cycles spent in wait; it restarts in every other state
    elapse_timer uBoostTmr (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .ce(ce),
        .restart(warmDone || r.st != ST_WAIT),
        .elapsed(boostTime)
    );

    assign faultAny = sMal || sMis;
    assign pwTempOk = heatRollTemp >= `T_PW_HEAT && pressRollTemp >= `T_PW_PRESS;
    assign restart = next_r.st != r.st;

    always_comb begin
        next_r = r;
        case (r.st)
            ST_IDLE: begin
                if (warmDone) begin
                    next_r.st = sReq ? ST_PROACT : ST_POSTWARM;
                end
            end
            ST_POSTWARM: begin
                if (sPs) begin
                    next_r.st = ST_HEATOFF;
                end else if (elapsed >= POSTWARM_CYC || pwTempOk) begin
                    next_r.st = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (faultAny || sPs || sDoor) begin
                    next_r.st = ST_HEATOFF;
                end else if (sReq) begin
                    next_r.st = ST_PRINT;
                end
            end
            ST_PROACT: begin
                if (faultAny || sPs || sDoor) begin
                    next_r.st = ST_HEATOFF;
                end else if (sStart) begin
                    next_r.st = ST_PRINT;
                end else if (elapsed >= PROACT_CYC) begin
                    next_r.st = ST_WAIT;
                end
            end
            ST_PRINT: begin
                if (faultAny || sDoor) begin
                    next_r.st = ST_HEATOFF;
                end else if (sExit && !sMore && !sReq) begin
                    next_r.st = ST_POSTPRINT;
                end
            end
            ST_POSTPRINT: begin
                if (sDoor || faultAny || sPs) begin
                    next_r.st = ST_HEATOFF;
                end else if (sReq) begin
                    next_r.st = ST_PRINT;
                end else if (elapsed >= PP_WAIT_CYC) begin
                    next_r.st = ST_WAIT;
                end
            end
            ST_HEATOFF: begin
                if (!sDoor && !faultAny && !sPs) begin
                    next_r.st = ST_IDLE;
                end
            end
            default: begin
                next_r.st = ST_IDLE;
            end
        endcase

        next_r.forceOff = 1'b0;
        next_r.revStop = 1'b0;
        case (next_r.st)
            ST_POSTWARM, ST_WAIT: begin
                next_r.l1 = boosted(10'(`T_PW_HEAT + correction), r.boost);
                next_r.l2 = `T_PW_PRESS;
                next_r.spd = (next_r.st == ST_POSTWARM) ? `SPD_STD : `SPD_STOP;
            end
            ST_PROACT: begin
                next_r.spd = `SPD_STD;
            end
            ST_PRINT: begin
                if (r.st != ST_PRINT) begin
                    next_r.l1 = boosted(mediaHeatTemp, r.boost);
                    next_r.l2 = mediaPressTemp;
                    next_r.spd = `SPD_STD;
                    next_r.firstSheet = 1'b1;
                end
                if (sLead && r.firstSheet) begin
                    next_r.spd = mediaSpeed;
                    next_r.firstSheet = 1'b0;
                end
                if (sNip && sMore) begin
                    next_r.l1 = boosted(mediaHeatTemp, r.boost);
                    next_r.l2 = mediaPressTemp;
                    next_r.spd = mediaSpeed;
                end
            end
            ST_POSTPRINT: begin
                next_r.l1 = boosted(10'(`T_PP_HEAT + correction), r.boost);
                next_r.l2 = `T_PP_PRESS;
                next_r.spd = (r.st == ST_POSTPRINT && elapsed >= PP_STOP_CYC) ?
                             `SPD_STOP : `SPD_STD;
            end
            ST_HEATOFF: begin
                next_r.forceOff = 1'b1;
                next_r.revStop = 1'b1;
                next_r.spd = `SPD_STOP;
                next_r.l1 = `T_ZERO;
                next_r.l2 = `T_ZERO;
            end
            default: begin
                next_r.spd = `SPD_STOP;
            end
        endcase

        if (warmDone) begin
            next_r.boost = 1'b1;
            next_r.pages = `PG_ZERO;
        end else if (r.boost) begin
            if (r.st == ST_PRINT && sNip) begin
                next_r.pages = r.pages + `PG_ONE;
                if (r.pages + `PG_ONE >= BOOST_PAGES) begin
                    next_r.boost = 1'b0;
                end
            end
            if (r.st == ST_WAIT && boostTime >= BOOST_IDLE_CYC) begin
                next_r.boost = 1'b0;
            end
        end

        if (next_r.st == ST_WAIT || next_r.st == ST_HEATOFF || sNoGap) begin
            next_r.ivl = 1'b0;
        end else if (sLL || sHH || sSmall || heatRollTemp < COLD_THRESH) begin
            next_r.ivl = 1'b1;
        end
        next_r.gap = next_r.ivl ? calcGap(mediaLength, next_r.spd) : `CNT_ZERO;
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            r <= '{st: ST_IDLE, default: '0};
        end else if (ce) begin
            r <= next_r;
        end
    end

    assign lamp1Target = r.l1;
    assign lamp2Target = r.l2;
    assign rollerSpeed = r.spd;
    assign heaterForceOff = r.forceOff;
    assign reverseStop = r.revStop;
    assign intervalActive = r.ivl;
    assign sheetGap = r.gap;
    assign seqState = r.st;

    property pHeatOff;
        @(posedge ref_clk) disable iff (!rstn)
        (ce && r.st == ST_HEATOFF) |-> (heaterForceOff && reverseStop && rollerSpeed == `SPD_STOP);
    endproperty
    AST_HEATOFF_OUT: assert property (pHeatOff) else $error("heater-off outputs wrong");
    AST_HOLD_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
        (ce && r.st == ST_HEATOFF && (sDoor || sPs)) |=> r.st == ST_HEATOFF)
        else $error("left heater-off early");
    AST_WAIT_PRINT: assert property (@(posedge ref_clk) disable iff (!rstn)
        (ce && r.st == ST_WAIT && sReq && !faultAny && !sPs && !sDoor) |=> r.st == ST_PRINT)
        else $error("wait ignored request");
    AST_WAIT_OFF: assert property (@(posedge ref_clk) disable iff (!rstn)
        (ce && r.st == ST_WAIT && sMal) |=> r.st == ST_HEATOFF)
        else $error("wait ignored fault");
    AST_STANDBY_L2: assert property (@(posedge ref_clk) disable iff (!rstn)
        (r.st == ST_WAIT) |-> lamp2Target == `T_PW_PRESS)
        else $error("wait lamp two target");
    AST_PP_L2: assert property (@(posedge ref_clk) disable iff (!rstn)
        (r.st == ST_POSTPRINT) |-> lamp2Target == `T_PP_PRESS)
        else $error("post-print lamp two target");
    AST_IVL_CANCEL: assert property (@(posedge ref_clk) disable iff (!rstn)
        (r.st == ST_WAIT || r.st == ST_HEATOFF) |-> !intervalActive && sheetGap == `CNT_ZERO)
        else $error("interval not cancelled");
    sequence sWarmNoReq;
        ce && r.st == ST_IDLE && warmDone && !sReq;
    endsequence
    AST_POSTWARM: assert property (@(posedge ref_clk) disable iff (!rstn)
        sWarmNoReq |=> r.st == ST_POSTWARM ##0 rollerSpeed == `SPD_STD)
        else $error("post-warm-up not entered");
    AST_PP_EXIT: assert property (@(posedge ref_clk) disable iff (!rstn)
        (ce && r.st == ST_POSTPRINT && sReq && !sDoor && !faultAny && !sPs) |=> r.st == ST_PRINT)
        else $error("post-print not abandoned");
endmodule : fuser_temperature_sequencer

// file: media_path_model.sv
// Behavioural media path: sheet edge sensors and follow-on flag.
// Assumes the sequencer's roller speed; edges are one-cycle pulses set on falling edges.
`timescale 1ns/10ps
module media_path_model (
    input wire logic ref_clk, // Clock
    input wire logic [1:0] rollerSpeed, // Roller speed from sequencer
    input wire logic jobGo, // Start a job
    input wire logic [7:0] jobSheets, // Sheets in the job
    output logic leadAtRegist, // Leading edge at registration
    output logic trailAtNip, // Trailing edge past nip
    output logic trailAtExit, // Trailing edge past exit
    output logic moreSheets, // Another sheet follows
    output logic busy // Job in progress
);
    task automatic pulse(ref logic s, input int gap);
        repeat (gap) @(negedge ref_clk);
        s = 1'b1;
        @(negedge ref_clk);
        s = 1'b0;
    endtask : pulse

    initial begin
        {leadAtRegist, trailAtNip, trailAtExit, moreSheets, busy} = 5'h00;
        forever begin
            @(posedge jobGo);
            busy = 1'b1;
            for (int i = 0; i < jobSheets; i++) begin
                moreSheets = (i + 1 < jobSheets);
                // Paper waits for the rollers to turn, for at most 200 cycles
                for (int t = 0; t < 200 && rollerSpeed === 2'h0; t++) @(negedge ref_clk);
                pulse(leadAtRegist, 6);
                pulse(trailAtNip, 30);
                pulse(trailAtExit, 20);
            end
            busy = 1'b0;
        end
    end
endmodule : media_path_model

// file: fuser_temperature_sequencer_tb_top.sv
// Self-checking bench for the fuser mode sequencer.
// Assumes the media path model and shortened timer parameters.
`timescale 1ns/10ps
`include "fuser_seq_defines.svh"
`define CHK(nm, e, a) check(nm, 32'(e), 32'(a))
module fuser_temperature_sequencer_tb_top;
    import fuser_seq_pkg::*;
    localparam logic [15:0] PW = 16'h0020, PA = 16'h0020, PS = 16'h0010;
    localparam logic [15:0] PWT = 16'h0020, BI = 16'h0030, GU = 16'h0010;
    localparam logic [9:0] BA = 10'h005;
    logic ref_clk, rstn, ce, warmDone, printReq, printStart, malfunction, misfeed, powerSave;
    logic doorOpen, leadAtRegist, trailAtNip, trailAtExit, moreSheets, ambLowLow, ambHighHigh;
    logic smallMedia, mediaNoGap, heaterForceOff, reverseStop, intervalActive, jobGo, jobBusy;
    logic [9:0] heatRollTemp, pressRollTemp, correction, mediaHeatTemp, mediaPressTemp;
    logic [9:0] lamp1Target, lamp2Target;
    logic [1:0] mediaSpeed, rollerSpeed;
    logic [7:0] mediaLength, jobSheets;
    logic [15:0] sheetGap;
    logic [5:0] seqState;
    int err_total = 0, checks = 0, n;

    fuser_temperature_sequencer #(.POSTWARM_CYC(PW), .PROACT_CYC(PA), .PP_STOP_CYC(PS),
        .PP_WAIT_CYC(PWT), .BOOST_IDLE_CYC(BI), .BOOST_PAGES(8'h02), .BOOST_ADD(BA),
        .COLD_THRESH(10'h096), .GAP_UNIT(GU)) fuser_temperature_sequencer_i (
        .ref_clk, .rstn, .ce, .warmDone, .printReq, .printStart, .malfunction, .misfeed,
        .powerSave, .doorOpen, .leadAtRegist, .trailAtNip, .trailAtExit, .moreSheets,
        .ambLowLow, .ambHighHigh, .smallMedia, .mediaNoGap, .heatRollTemp, .pressRollTemp,
        .correction, .mediaHeatTemp, .mediaPressTemp, .mediaSpeed, .mediaLength,
        .lamp1Target, .lamp2Target, .rollerSpeed, .heaterForceOff, .reverseStop,
        .intervalActive, .sheetGap, .seqState);
    media_path_model media_path_model_i (.ref_clk, .rollerSpeed, .jobGo, .jobSheets,
        .leadAtRegist, .trailAtNip, .trailAtExit, .moreSheets, .busy(jobBusy));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic check(string nm, logic [31:0] e, logic [31:0] a);
        checks++;
        if (a !== e) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, a);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    task automatic cyc(int k);
        repeat (k) @(negedge ref_clk);
    endtask : cyc
    task automatic wait_st(logic [5:0] s, int lim);
        for (int i = 0; i < lim && seqState !== s; i++) @(negedge ref_clk);
        `CHK("seqState", s, seqState);
        if (seqState !== s) tally_and_finish();
    endtask : wait_st
    // Sensor pulses are polled on rising edges, where they are settled
    task automatic wait_pin(int w);
        logic [3:0] v;
        for (int i = 0; i < 300; i++) begin
            @(posedge ref_clk);
            v = {!jobBusy, trailAtExit, trailAtNip, leadAtRegist};
            if (v[w] === 1'b1) break;
        end
        `CHK("sensor event", 1'b1, v[w]);
        if (v[w] !== 1'b1) tally_and_finish();
        @(negedge ref_clk);
    endtask : wait_pin
    task automatic set_cause(int k, logic v);
        case (k)
            0: malfunction = v;
            1: misfeed = v;
            2: powerSave = v;
            default: doorOpen = v;
        endcase
    endtask : set_cause
    task automatic warm();
        warmDone = 1'b1;
        cyc(1);
        warmDone = 1'b0;
    endtask : warm
    task automatic job(int k);
        jobSheets = 8'(k);
        jobGo = 1'b1;
        cyc(1);
        jobGo = 1'b0;
    endtask : job
    task automatic new_media();
        mediaHeatTemp = 10'($urandom_range(160, 200));
        mediaPressTemp = 10'($urandom_range(130, 160));
        mediaSpeed = 2'($urandom_range(2, 3));
        mediaLength = 8'($urandom_range(1, 255));
    endtask : new_media
    function automatic logic [15:0] exp_gap(logic [7:0] len, logic [1:0] spd);
        return 16'((32'(len) * 32'(GU)) >> spd);
    endfunction : exp_gap
    function automatic logic [9:0] exp_l1(logic [9:0] base, logic boost);
        return base + correction + (boost ? BA : `T_ZERO);
    endfunction : exp_l1

    initial begin
        repeat (100000) @(posedge ref_clk);
        err_total++;
        tally_and_finish();
    end

    initial begin
        void'($urandom(32'hA197));
        {rstn, ce, warmDone, printReq, printStart, malfunction, misfeed, powerSave} = 8'h40;
        {doorOpen, ambLowLow, ambHighHigh, smallMedia, mediaNoGap, jobGo} = 6'h00;
        {heatRollTemp, pressRollTemp} = {10'h0A0, 10'h08C};
        correction = 10'($urandom_range(0, 31));
        {mediaHeatTemp, mediaPressTemp, mediaSpeed, mediaLength, jobSheets} = '0;
        cyc(6);
        rstn = 1'b1;
        `CHK("seqState", ST_IDLE, seqState);
        `CHK("targets", 0, {lamp1Target, lamp2Target, rollerSpeed});
        `CHK("flags", 0, {heaterForceOff, reverseStop, intervalActive, sheetGap});
        $display("test reset done");
        warm();
        wait_st(ST_POSTWARM, 4);
        cyc(1);
        `CHK("rollerSpeed", `SPD_STD, rollerSpeed);
        `CHK("lamp1Target", exp_l1(`T_PW_HEAT, 1'b1), lamp1Target);
        `CHK("lamp2Target", `T_PW_PRESS, lamp2Target);
        cyc(16);
        `CHK("seqState", ST_POSTWARM, seqState);
        wait_st(ST_WAIT, PW);
        `CHK("lamp1Target", exp_l1(`T_PW_HEAT, 1'b1), lamp1Target);
        cyc(BI + 4);
        `CHK("lamp1Target", exp_l1(`T_PW_HEAT, 1'b0), lamp1Target);
        `CHK("lamp2Target", `T_PW_PRESS, lamp2Target);
        $display("test post-warm-up done");
        {heatRollTemp, pressRollTemp} = {`T_PW_HEAT, `T_PW_PRESS};
        for (int k = 0; k < 4; k++) begin
            set_cause(k, 1'b1);
            wait_st(ST_HEATOFF, 6);
            `CHK("offReq", 4'hC, {heaterForceOff, reverseStop, rollerSpeed});
            `CHK("lamp1Target", `T_ZERO, lamp1Target);
            set_cause((k + 1) % 4, 1'b1);
            set_cause(k, 1'b0);
            cyc(8);
            `CHK("seqState", ST_HEATOFF, seqState);
            set_cause((k + 1) % 4, 1'b0);
            wait_st(ST_IDLE, 6);
            pressRollTemp = (k == 3) ? 10'h08C : `T_PW_PRESS;
            warm();
            wait_st(k == 3 ? ST_POSTWARM : ST_WAIT, 6);
        end
        powerSave = 1'b1;
        wait_st(ST_HEATOFF, 6);
        powerSave = 1'b0;
        pressRollTemp = `T_PW_PRESS;
        wait_st(ST_IDLE, 6);
        warm();
        wait_st(ST_WAIT, 6);
        ce = 1'b0;
        printReq = 1'b1;
        cyc(6);
        printReq = 1'b0;
        cyc(1);
        ce = 1'b1;
        cyc(BI + 4);
        `CHK("seqState", ST_WAIT, seqState);
        $display("test heater-off done");
        new_media();
        printReq = 1'b1;
        wait_st(ST_PRINT, 6);
        printReq = 1'b0;
        job(2);
        `CHK("lamps", {mediaHeatTemp, mediaPressTemp}, {lamp1Target, lamp2Target});
        `CHK("rollerSpeed", `SPD_STD, rollerSpeed);
        wait_pin(0);
        cyc(4);
        `CHK("rollerSpeed", mediaSpeed, rollerSpeed);
        smallMedia = 1'b1;
        cyc(4);
        `CHK("intervalActive", 1'b1, intervalActive);
        `CHK("sheetGap", exp_gap(mediaLength, mediaSpeed), sheetGap);
        mediaNoGap = 1'b1;
        cyc(4);
        `CHK("intervalActive", 1'b0, intervalActive);
        {smallMedia, mediaNoGap} = 2'b00;
        new_media();
        wait_pin(1);
        cyc(4);
        `CHK("lamps", {mediaHeatTemp, mediaPressTemp}, {lamp1Target, lamp2Target});
        `CHK("rollerSpeed", mediaSpeed, rollerSpeed);
        wait_pin(2);
        cyc(4);
        `CHK("seqState", ST_PRINT, seqState);
        wait_pin(3);
        wait_st(ST_POSTPRINT, 8);
        `CHK("lamp1Target", exp_l1(`T_PP_HEAT, 1'b0), lamp1Target);
        `CHK("lamp2Target", `T_PP_PRESS, lamp2Target);
        `CHK("rollerSpeed", `SPD_STD, rollerSpeed);
        ambHighHigh = 1'b1;
        for (n = 1; n < 64 && rollerSpeed !== `SPD_STOP; n++) cyc(1);
        `CHK("stop delay", 1'b1, n >= PS - 2 && n <= PS + 2);
        `CHK("intervalActive", 1'b1, intervalActive);
        `CHK("seqState", ST_POSTPRINT, seqState);
        wait_st(ST_WAIT, PWT);
        cyc(2);
        `CHK("intervalActive", 1'b0, intervalActive);
        ambHighHigh = 1'b0;
        $display("test print done");
        for (int j = 0; j < 3; j++) begin
            powerSave = 1'b1;
            wait_st(ST_HEATOFF, 6);
            {malfunction, misfeed, powerSave, doorOpen, printReq} = 5'h01;
            wait_st(ST_IDLE, 6);
            warm();
            wait_st(ST_PROACT, 4);
            printReq = 1'b0;
            `CHK("rollerSpeed", `SPD_STD, rollerSpeed);
            case (j)
                0: begin
                    ambLowLow = 1'b1;
                    cyc(4);
                    `CHK("intervalActive", 1'b1, intervalActive);
                    ambLowLow = 1'b0;
                    wait_st(ST_WAIT, PA + 8);
                end
                1: begin
                    printStart = 1'b1;
                    wait_st(ST_PRINT, 6);
                    printStart = 1'b0;
                    heatRollTemp = 10'h080;
                    cyc(4);
                    `CHK("intervalActive", 1'b1, intervalActive);
                    heatRollTemp = `T_PW_HEAT;
                    doorOpen = 1'b1;
                    wait_st(ST_HEATOFF, 6);
                end
                default: begin
                    misfeed = 1'b1;
                    wait_st(ST_HEATOFF, 6);
                end
            endcase
        end
        $display("test proactive done");
        misfeed = 1'b0;
        wait_st(ST_IDLE, 6);
        warm();
        wait_st(ST_WAIT, 6);
        for (int r = 0; r < 2; r++) begin
            printReq = 1'b1;
            wait_st(ST_PRINT, 6);
            printReq = 1'b0;
            job(1);
            wait_pin(3);
            wait_st(ST_POSTPRINT, 8);
            `CHK("lamp1Target", exp_l1(`T_PP_HEAT, r == 0), lamp1Target);
        end
        set_cause($urandom_range(0, 1) ? 3 : 0, 1'b1);
        wait_st(ST_HEATOFF, 6);
        $display("test post-print abandon done");
        tally_and_finish();
    end
endmodule : fuser_temperature_sequencer_tb_top
